// [rtl/kir_top.sv]
// Key interrupt block with an AHB-Lite register slave and one interrupt output.
// Assumes one clock, a single AHB-Lite master doing single word transfers.
//
// Contract
// - A falling edge on an enabled key raises the key interrupt request only while all other enabled keys are high.
// - No request while any enabled key is held low.
// - Enable bit k controls key k; disabled keys have no effect.
// - The enable register is accessible as a whole byte and as single bits.
// - Reset clears the enable register to zero.
// - Writing the enable register may itself raise a request.
`timescale 1ns/100ps
`include "kir_defines.svh"

module kir_top #(
  parameter int NUM_KEYS = `KIR_NUM_KEYS
) (
  input  wire logic                clock,
  input  wire logic                resetn,
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic      [31:0]         hrdata,
  output logic                     hreadyout,
  output logic                     hresp,
  input  wire logic [NUM_KEYS-1:0] key_inputs,
  output logic                     key_interrupt_request,
  output logic                     irq
);

  // ----------------------------------------------------------------
  // Address phase capture
  // ----------------------------------------------------------------
  kir_pkg::kir_bus_state_t bus_state;
  kir_pkg::kir_bus_state_t next_bus_state;
  logic [11:0]             addr_q;
  logic [11:0]             next_addr_q;
  logic                    take;

  assign take = hsel & hready & htrans[1];

  always_comb begin
    next_bus_state = kir_pkg::KIR_BUS_IDLE;
    next_addr_q    = addr_q;
    if (take) begin
      next_addr_q    = haddr[11:0];
      next_bus_state = hwrite ? kir_pkg::KIR_BUS_WRITE : kir_pkg::KIR_BUS_READ;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      bus_state <= kir_pkg::KIR_BUS_IDLE;
      addr_q    <= 12'h000;
    end else begin
      bus_state <= next_bus_state;
      addr_q    <= next_addr_q;
    end
  end

  // Zero wait states; every access, mapped or not, answers OKAY.
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ----------------------------------------------------------------
  // Key path
  // ----------------------------------------------------------------
  logic [NUM_KEYS-1:0] key_level;
  logic [NUM_KEYS-1:0] key_input_enable_reg;
  logic                key_event;

  kir_sync #(
    .WIDTH (NUM_KEYS)
  ) u_sync (
    .clock    (clock),
    .resetn   (resetn),
    .async_in (key_inputs),
    .sync_out (key_level)
  );

  kir_detect #(
    .WIDTH (NUM_KEYS)
  ) u_detect (
    .clock                 (clock),
    .resetn                (resetn),
    .key_level             (key_level),
    .key_input_enable_bits (key_input_enable_reg),
    .key_interrupt_request (key_event)
  );

  assign key_interrupt_request = key_event;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic                key_irq_pending_flag;
  logic                key_irq_mask;
  logic [NUM_KEYS-1:0] next_enable;
  logic                next_pending;
  logic                next_mask;
  logic                wr;
  logic                rd;
  logic [2:0]          bit_sel;

  assign wr      = (bus_state == kir_pkg::KIR_BUS_WRITE);
  assign rd      = (bus_state == kir_pkg::KIR_BUS_READ);
  assign bit_sel = hwdata[2:0];

  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a[11:2] == ofs[11:2]);
  endfunction

  always_comb begin
    next_enable  = key_input_enable_reg;
    next_mask    = key_irq_mask;
    next_pending = key_irq_pending_flag;
    if (wr && hit(addr_q, `KIR_OFS_ENABLE)) begin
      next_enable = hwdata[NUM_KEYS-1:0];
    end
    // Single-bit access: the low bits of the write data name the key.
    if (wr && hit(addr_q, `KIR_OFS_BIT_SET)) begin
      next_enable[bit_sel] = 1'b1;
    end
    if (wr && hit(addr_q, `KIR_OFS_BIT_CLEAR)) begin
      next_enable[bit_sel] = 1'b0;
    end
    if (wr && hit(addr_q, `KIR_OFS_MASK)) begin
      next_mask = hwdata[0];
    end
    // A status read clears only what it returned, so an event that lands after
    // the read data was captured stays pending; a same-cycle event wins too.
    if (rd && hit(addr_q, `KIR_OFS_STATUS) && hrdata[`KIR_STATUS_KEY_BIT]) begin
      next_pending = 1'b0;
    end
    if (key_event) begin
      next_pending = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      key_input_enable_reg <= `KIR_ENABLE_RESET;
      key_irq_mask         <= `KIR_MASK_RESET;
      key_irq_pending_flag <= 1'b0;
    end else begin
      key_input_enable_reg <= next_enable;
      key_irq_mask         <= next_mask;
      key_irq_pending_flag <= next_pending;
    end
  end

  // Mask bit set means the interrupt is allowed through.
  assign irq = key_irq_pending_flag & key_irq_mask;

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [31:0] next_hrdata;

  always_comb begin
    next_hrdata = 32'h0000_0000;
    if (take && !hwrite) begin
      if (hit(haddr[11:0], `KIR_OFS_ENABLE)) begin
        next_hrdata[NUM_KEYS-1:0] = key_input_enable_reg;
      end
      if (hit(haddr[11:0], `KIR_OFS_STATUS)) begin
        next_hrdata[`KIR_STATUS_KEY_BIT] = key_irq_pending_flag;
      end
      if (hit(haddr[11:0], `KIR_OFS_MASK)) begin
        next_hrdata[0] = key_irq_mask;
      end
      if (hit(haddr[11:0], `KIR_OFS_KEY_LEVEL)) begin
        next_hrdata[NUM_KEYS-1:0] = key_level;
      end
    end
  end

  // Read data is sampled at the address phase so it stands for the data phase.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      hrdata <= 32'h0000_0000;
    end else begin
      hrdata <= next_hrdata;
    end
  end

endmodule // kir_top

// [rtl/kir_defines.svh]
// Register offsets, field layout, reset values and timing counts of the key interrupt block.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef KIR_DEFINES_SVH
`define KIR_DEFINES_SVH

`define KIR_NUM_KEYS        8
`define KIR_OFS_ENABLE      12'h000
`define KIR_OFS_STATUS      12'h004
`define KIR_OFS_MASK        12'h008
`define KIR_OFS_KEY_LEVEL   12'h00C
`define KIR_OFS_BIT_SET     12'h010
`define KIR_OFS_BIT_CLEAR   12'h014
`define KIR_ENABLE_RESET    8'h00
`define KIR_MASK_RESET      1'h0
`define KIR_STATUS_KEY_BIT  0
`define KIR_SYNC_STAGES     2

`endif

// [rtl/kir_pkg.sv]
// Types shared by the key interrupt block.
// Assumes the defines header is on the include path.
`include "kir_defines.svh"

package kir_pkg;

  typedef logic [`KIR_NUM_KEYS-1:0] kir_keys_t;

  typedef enum logic [1:0] {
    KIR_BUS_IDLE  = 2'h0,
    KIR_BUS_WRITE = 2'h1,
    KIR_BUS_READ  = 2'h3
  } kir_bus_state_t;

endpackage

// [rtl/kir_sync.sv]
// Two-stage level synchroniser for a vector of key inputs.
// Assumes inputs may change at any time relative to clock.
`timescale 1ns/100ps
`include "kir_defines.svh"

module kir_sync #(
  parameter int WIDTH = `KIR_NUM_KEYS
) (
  input  wire logic             clock,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_sync_out;

  always_comb begin
    next_stage1   = async_in;
    next_sync_out = stage1;
  end

  // Resets high so that idle released keys cause no edge after reset.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      stage1   <= {WIDTH{1'b1}};
      sync_out <= {WIDTH{1'b1}};
    end else begin
      stage1   <= next_stage1;
      sync_out <= next_sync_out;
    end
  end

endmodule // kir_sync

// [rtl/kir_detect.sv]
// Combined-level falling edge detector over the enabled key inputs.
// Assumes synchronised key levels and the enable vector in the clock domain.
`timescale 1ns/100ps
`include "kir_defines.svh"

module kir_detect #(
  parameter int WIDTH = `KIR_NUM_KEYS
) (
  input  wire logic             clock,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] key_level,
  input  wire logic [WIDTH-1:0] key_input_enable_bits,
  output logic                  key_interrupt_request
);

  logic combined;
  logic combined_q;
  logic next_combined_q;

  // A disabled key reads as high, so it cannot pull the combined level down.
  assign combined = &(key_level | ~key_input_enable_bits);

  always_comb begin
    next_combined_q = combined;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      combined_q <= 1'b1;
    end else begin
      combined_q <= next_combined_q;
    end
  end

  // An enabled key held low keeps the combined level low, hiding later edges on others.
  // Changing the enable vector can also drop the level and raise a request.
  assign key_interrupt_request = combined_q & ~combined;

endmodule // kir_detect

// [dv/kir_top_assertions.sv]
// Port checker for the key interrupt block.
// Assumes one clock and binding to kir_top.
`timescale 1ns/100ps
module kir_top_checker #(
  parameter int NUM_KEYS = 8
) (
  input wire logic                clock,
  input wire logic                resetn,
  input wire logic                hsel,
  input wire logic [1:0]          htrans,
  input wire logic                hwrite,
  input wire logic                hready,
  input wire logic [31:0]         hrdata,
  input wire logic                hreadyout,
  input wire logic                hresp,
  input wire logic [NUM_KEYS-1:0] key_inputs,
  input wire logic                key_interrupt_request,
  input wire logic                irq
);
  logic take;
  assign take = hsel && htrans[1] && hready;
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  a_ready_always: assert property (hreadyout) else $error("hreadyout low");
  a_resp_okay: assert property (!hresp) else $error("hresp not okay");
  a_request_pulse: assert property (key_interrupt_request |=> !key_interrupt_request)
    else $error("request longer than one cycle");
  a_request_key_low: assert property (key_interrupt_request |-> $past(key_inputs, 2) != '1)
    else $error("request with no key low");
  a_request_cause: assert property (key_interrupt_request |->
    ($past(key_inputs, 3) & ~$past(key_inputs, 2)) != '0 || $past(take && hwrite, 2))
    else $error("request without a fall or a write");
  a_irq_rise_cause: assert property ($rose(irq) |->
    $past(key_interrupt_request) || $past(take && hwrite, 2)) else $error("irq rose alone");
  a_irq_fall_cause: assert property ($fell(irq) |-> $past(take, 2))
    else $error("irq fell without an access");
  a_rdata_idle: assert property (!$past(take && !hwrite) |-> hrdata == 32'h0)
    else $error("hrdata outside a read");
endmodule // kir_top_checker

bind kir_top kir_top_checker #(.NUM_KEYS(NUM_KEYS)) u_chk (.clock, .resetn, .hsel, .htrans,
  .hwrite, .hready, .hrdata, .hreadyout, .hresp, .key_inputs, .key_interrupt_request, .irq);

// [dv/kir_key_switches.sv]
// Key switches on the key pins, pulled up while open.
// Assumes the bench calls set_key from its own process.
`timescale 1ns/100ps
module kir_key_switches #(
  parameter int NUM_KEYS = 8
) (
  input  wire logic                clock,
  output logic      [NUM_KEYS-1:0] key_inputs
);
  initial key_inputs = '1;
  // The line changes just after an edge, unrelated to the sampling inside.
  task automatic set_key(input int k, input logic pressed);
    @(posedge clock);
    key_inputs[k] <= !pressed;
  endtask
endmodule // kir_key_switches

// [dv/kir_top_bench.sv]
// Self-checking bench for the key interrupt block.
// Assumes the key switch model and the port checker.
`timescale 1ns/100ps
module kir_top_bench;
  logic        clock = 0;
  logic        resetn = 0;
  logic        hsel = 0;
  logic        hwrite = 0;
  logic [31:0] haddr = '0;
  logic [31:0] hwdata = '0;
  logic [1:0]  htrans = '0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic        hreadyout;
  logic        hresp;
  logic        key_interrupt_request;
  logic        irq;
  logic [7:0]  key_inputs;
  wire         hready = hreadyout;
  int          num_errors = 0;
  int          comparisons = 0;
  always #10 clock = ~clock;
  kir_top dut (.clock, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hrdata, .hreadyout, .hresp, .key_inputs, .key_interrupt_request, .irq);
  kir_key_switches keys (.clock, .key_inputs);
  // Ready and read data are taken at the rising edge, before registers move.
  task automatic phase();
    do begin
      @(posedge clock);
    end while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    phase();
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    phase();
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic chk_irq(input string s, input logic e);
    comparisons++;
    if (irq !== e) begin
      num_errors++;
      $display("ERROR %s expected %b seen %b", s, e, irq);
    end
  endtask
  task automatic rchk(input string s, input logic [31:0] a, input logic [31:0] e);
    xfer(0, a, 32'h0);
    chk(s, e, rd);
  endtask
  task automatic keyset(input int k, input logic p);
    keys.set_key(k, p);
    repeat (5) @(posedge clock);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge clock);
    num_errors++;
    conclude();
  end
  initial begin
    repeat (6) @(posedge clock);
    resetn <= 1;
    rchk("enable", 32'h00, 32'h0);
    rchk("unmapped", 32'h20, 32'h0);
    rchk("levels", 32'h0C, 32'hFF);
    xfer(1, 32'h08, 32'h1);
    xfer(1, 32'h00, 32'h1);
    keyset(0, 1);
    chk_irq("irq", 1'b1);
    rchk("status", 32'h04, 32'h1);
    rchk("status", 32'h04, 32'h0);
    chk_irq("irq", 1'b0);
    $display("test single key done");
    xfer(1, 32'h00, 32'h3);
    keyset(1, 1);
    rchk("status", 32'h04, 32'h0);
    keyset(0, 0);
    keyset(1, 0);
    keyset(2, 1);
    rchk("status", 32'h04, 32'h0);
    keyset(2, 0);
    $display("test blocking done");
    xfer(1, 32'h08, 32'h0);
    keyset(5, 1);
    xfer(1, 32'h00, 32'h20);
    repeat (3) @(posedge clock);
    chk_irq("masked irq", 1'b0);
    rchk("status", 32'h04, 32'h1);
    xfer(1, 32'h08, 32'h1);
    @(posedge clock);
    chk_irq("unmasked irq", 1'b0);
    keyset(5, 0);
    $display("test enable write done");
    xfer(1, 32'h14, 32'h5);
    for (int k = 0; k < 8; k++) begin
      xfer(1, 32'h10, k);
      rchk("bit set", 32'h00, 32'h1 << k);
      xfer(1, 32'h14, k);
      rchk("bit clear", 32'h00, 32'h0);
    end
    $display("test bit access done");
    conclude();
  end
endmodule // kir_top_bench
